// File: evol_event_output.sv
/*
 * Event output logic of a program controller: three configurable events,
 * standby suppression, ON delay, advance pulse and timed output assignment.
 * Assumes all inputs come from logic on the same clock, and that mode
 * inputs are one-hot levels from the program sequencer.
 */
`timescale 1ns/1ns
module evol_event_output #(
   parameter int TICKS_PER_SECOND = evol_pkg::EVOL_SEC_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Controller modes
   input wire logic mode_ready,
   input wire logic mode_run,
   input wire logic mode_hold,
   input wire logic mode_fast,
   input wire logic mode_end,
   // Controller status
   input wire logic gsoak_wait,
   input wire logic manual_mode,
   input wire logic autotune_busy,
   input wire logic const_value_op,
   input wire logic alarm_any,
   input wire logic alarm_range,
   input wire logic alarm_controller,
   input wire logic battery_low,
   input wire logic console_setup,
   input wire logic loader_setup,
   input wire logic advance_request,
   // Process quantities, signed engineering units or 0.1 percent
   input wire logic signed [15:0] pv,
   input wire logic signed [15:0] deviation,
   input wire logic signed [15:0] setpoint,
   input wire logic signed [15:0] output_mv,
   input wire logic signed [15:0] motor_feedback,
   // Time events and segment number
   input wire logic [2:0] event_time_in,
   input wire logic [4:0] time_event_bits,
   input wire logic [4:0] segment_no_bits,
   // Configuration writes
   input wire logic cfg_wr,
   input wire logic [1:0] cfg_sel,
   input wire logic [2:0] cfg_item,
   input wire logic [15:0] cfg_data,
   output logic cfg_ack,
   output logic cfg_reject,
   // Results
   output logic [2:0] event_out,
   output logic [2:0] standby_active,
   output logic [4:0] timed_output,
   output logic [2:0] time_event_type
);

   // ------------------------------------------------------------
   // Shared timing, mode tracking and status vector
   // ------------------------------------------------------------
   logic [23:0] sec_cnt_reg, sec_cnt_next;
   logic sec_tick_reg, sec_tick_next;
   logic [23:0] adv_cnt_reg, adv_cnt_next;
   logic [2:0] time_type_reg, time_type_next;
   logic [4:0] timed_reg, timed_next;
   logic ack_reg, reject_reg, ack_next, reject_next;
   logic ready_prev_reg, time_type_ok, ready_to_run, active_mode, adv_busy;
   logic [2:0] accept;
   logic [evol_pkg::EVOL_STATUS_BITS-1:0] status_vec;

   assign ready_to_run = ready_prev_reg && mode_run;
   assign active_mode = mode_run || mode_hold || mode_fast;
   assign adv_busy = adv_cnt_reg != 24'h000000;

   // Status conditions indexed by type code minus 100, code 110 unused
   assign status_vec = {loader_setup, console_setup, battery_low, alarm_controller, alarm_range, alarm_any,
                        1'b0, const_value_op, autotune_busy, manual_mode, gsoak_wait, mode_end, mode_fast,
                        mode_hold, mode_run, mode_ready,
                        mode_run || mode_hold || mode_fast || mode_end};

   // Second tick, advance pulse timer, time event type and timed outputs
   always_comb begin
      sec_cnt_next = sec_cnt_reg + 24'h000001;
      sec_tick_next = 1'b0;
      if (sec_cnt_reg == 24'(TICKS_PER_SECOND - 1)) begin
         sec_cnt_next = 24'h000000;
         sec_tick_next = 1'b1;
      end
      // Retriggerable one second on-time
      adv_cnt_next = adv_cnt_reg;
      if (advance_request) begin
         adv_cnt_next = 24'(TICKS_PER_SECOND);
      end else if (adv_busy) begin
         adv_cnt_next = adv_cnt_reg - 24'h000001;
      end
      // Changes accepted only in ready mode and in range
      time_type_ok = mode_ready && cfg_data <= evol_pkg::EVOL_TIME_TYPE_MAX;
      time_type_next = time_type_reg;
      if (cfg_wr && cfg_sel == 2'h3 && cfg_item == evol_pkg::EVOL_ITEM_TIME_TYPE && time_type_ok) begin
         time_type_next = cfg_data[2:0];
      end
      for (int k = 0; k < evol_pkg::EVOL_TIMED; k++) begin
         timed_next[k] = (k < int'(time_type_reg)) ? segment_no_bits[k] : time_event_bits[k];
      end
      ack_next = 1'b0;
      reject_next = 1'b0;
      if (cfg_wr) begin
         if (cfg_sel == 2'h3) begin
            ack_next = cfg_item == evol_pkg::EVOL_ITEM_TIME_TYPE && time_type_ok;
         end else begin
            ack_next = accept[cfg_sel];
         end
         reject_next = !ack_next;
      end
   end

   // Registers of the shared section
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sec_cnt_reg <= 24'h000000;
         sec_tick_reg <= 1'b0;
         adv_cnt_reg <= 24'h000000;
         ready_prev_reg <= 1'b0;
         time_type_reg <= evol_pkg::EVOL_TIME_TYPE_RST;
         timed_reg <= 5'h00;
         ack_reg <= 1'b0;
         reject_reg <= 1'b0;
      end else begin
         sec_cnt_reg <= sec_cnt_next;
         sec_tick_reg <= sec_tick_next;
         adv_cnt_reg <= adv_cnt_next;
         ready_prev_reg <= mode_ready;
         time_type_reg <= time_type_next;
         timed_reg <= timed_next;
         ack_reg <= ack_next;
         reject_reg <= reject_next;
      end
   end

   // ------------------------------------------------------------
   // Per-event settings, comparison, standby and delay
   // ------------------------------------------------------------
   generate
      for (genvar gi = 0; gi < evol_pkg::EVOL_EVENTS; gi++) begin : g_event
         logic [7:0] type_reg, type_next;
         logic stby_item_reg, stby_item_next;
         logic [7:0] hyst_reg, hyst_next;
         logic [11:0] delay_reg, delay_next;
         logic signed [15:0] point_reg, point_next;
         logic cmp_reg, cmp_next;
         logic stby_reg, stby_next;
         logic out_reg, out_next;
         logic signed [17:0] val, pt, lo, hi;
         logic [7:0] status_idx;
         logic meas, adv_sel, on_cond, off_raw, off_hyst, pre_cond, hit, delayed, acc;

         assign meas = type_reg <= evol_pkg::EVOL_TYPE_MEAS_LAST;
         assign adv_sel = type_reg == evol_pkg::EVOL_TYPE_ADV;
         assign hit = cfg_wr && cfg_sel == 2'(gi);
         assign status_idx = type_reg - evol_pkg::EVOL_TYPE_STATUS_FIRST;
         assign accept[gi] = acc;

         // Settings writes with range and availability checks
         always_comb begin
            type_next = type_reg;
            stby_item_next = stby_item_reg;
            hyst_next = hyst_reg;
            delay_next = delay_reg;
            point_next = point_reg;
            acc = 1'b0;
            if (hit) begin
               case (cfg_item)
                  evol_pkg::EVOL_ITEM_TYPE: acc = cfg_data <= 16'(evol_pkg::EVOL_TYPE_MAX);
                  evol_pkg::EVOL_ITEM_STANDBY: acc = type_reg < evol_pkg::EVOL_TYPE_UNAVAIL &&
                                                     cfg_data <= evol_pkg::EVOL_STANDBY_MAX;
                  evol_pkg::EVOL_ITEM_HYST: acc = type_reg < evol_pkg::EVOL_TYPE_UNAVAIL &&
                                                  cfg_data <= evol_pkg::EVOL_HYST_MAX;
                  evol_pkg::EVOL_ITEM_DELAY: acc = cfg_data <= evol_pkg::EVOL_DELAY_MAX;
                  evol_pkg::EVOL_ITEM_POINT: acc = 1'b1;
                  default: acc = 1'b0;
               endcase
            end
            if (acc) begin
               case (cfg_item)
                  evol_pkg::EVOL_ITEM_TYPE: type_next = cfg_data[7:0];
                  evol_pkg::EVOL_ITEM_STANDBY: stby_item_next = cfg_data[0];
                  evol_pkg::EVOL_ITEM_HYST: hyst_next = cfg_data[7:0];
                  evol_pkg::EVOL_ITEM_DELAY: delay_next = cfg_data[11:0];
                  default: point_next = cfg_data;
               endcase
            end
         end

         // Comparison with hysteresis, standby and pre-delay condition
         always_comb begin
            case (type_reg[3:1])
               3'h0: val = 18'(pv);
               3'h1: val = 18'(deviation);
               3'h2: val = deviation[15] ? -18'(deviation) : 18'(deviation);
               3'h3: val = 18'(setpoint);
               3'h4: val = 18'(output_mv);
               default: val = 18'(motor_feedback);
            endcase
            pt = 18'(point_reg);
            lo = pt - $signed({10'h000, hyst_reg});
            hi = pt + $signed({10'h000, hyst_reg});
            on_cond = type_reg[0] ? (val <= pt) : (val >= pt);
            off_raw = type_reg[0] ? (val > pt) : (val < pt);
            off_hyst = type_reg[0] ? (val > hi) : (val < lo);
            cmp_next = cmp_reg;
            if (!meas) begin
               cmp_next = 1'b0;
            end else if (on_cond) begin
               cmp_next = 1'b1;
            end else if (off_hyst) begin
               cmp_next = 1'b0;
            end
            stby_next = stby_reg;
            if (!stby_item_reg || (active_mode && off_raw)) begin
               stby_next = 1'b0;
            end
            if (mode_ready || ready_to_run) begin
               stby_next = 1'b1;
            end
            pre_cond = 1'b0;
            if (meas) begin
               pre_cond = cmp_reg && !(stby_item_reg && stby_reg);
            end else if (type_reg == evol_pkg::EVOL_TYPE_TIME) begin
               pre_cond = event_time_in[gi];
            end else if (type_reg >= evol_pkg::EVOL_TYPE_STATUS_FIRST &&
                         type_reg <= evol_pkg::EVOL_TYPE_STATUS_LAST) begin
               pre_cond = status_vec[status_idx[4:0]];
            end
            // Advance bypasses the delay timer
            out_next = adv_sel ? adv_busy : delayed;
         end

         // ON delay applied to the condition after standby
         evol_on_delay u_delay (
            .clk(clk),
            .rst(rst),
            .sec_tick(sec_tick_reg),
            .delay_s(delay_reg),
            .cond(pre_cond && !adv_sel),
            .delayed_on(delayed)
         );

         // Registers of one event
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               type_reg <= evol_pkg::EVOL_TYPE_RST;
               stby_item_reg <= evol_pkg::EVOL_STANDBY_ITEM_RST;
               hyst_reg <= evol_pkg::EVOL_HYST_RST;
               delay_reg <= evol_pkg::EVOL_DELAY_RST;
               point_reg <= evol_pkg::EVOL_POINT_RST;
               cmp_reg <= 1'b0;
               stby_reg <= 1'b1;
               out_reg <= 1'b0;
            end else begin
               type_reg <= type_next;
               stby_item_reg <= stby_item_next;
               hyst_reg <= hyst_next;
               delay_reg <= delay_next;
               point_reg <= point_next;
               cmp_reg <= cmp_next;
               stby_reg <= stby_next;
               out_reg <= out_next;
            end
         end

         assign event_out[gi] = out_reg;
         assign standby_active[gi] = stby_reg;
      end
   endgenerate

   // Outputs from registers
   assign timed_output = timed_reg;
   assign time_event_type = time_type_reg;
   assign cfg_ack = ack_reg;
   assign cfg_reject = reject_reg;

endmodule : evol_event_output

// File: evol_event_output_props.sv
/*
 * Checker for the event output logic: write answers, standby entry and
 * timed output mapping.
 * Assumes it is bound to evol_event_output and sees only its ports.
 */
`timescale 1ns/1ns
module evol_event_output_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Modes
   input wire logic mode_ready,
   input wire logic mode_run,
   // Timed output sources
   input wire logic [4:0] time_event_bits,
   input wire logic [4:0] segment_no_bits,
   // Configuration
   input wire logic cfg_wr,
   input wire logic [1:0] cfg_sel,
   input wire logic [2:0] cfg_item,
   input wire logic [15:0] cfg_data,
   input wire logic cfg_ack,
   input wire logic cfg_reject,
   // Results
   input wire logic [2:0] event_out,
   input wire logic [2:0] standby_active,
   input wire logic [4:0] timed_output,
   input wire logic [2:0] time_event_type
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Low n bits set: the timed outputs that carry segment numbers
   function automatic logic [4:0] seg_mask(input logic [2:0] n);
      logic [5:0] m;
      m = (6'h01 << n) - 6'h01;
      return m[4:0];
   endfunction : seg_mask

   // --------------------------------------------------------
   // Checks
   // --------------------------------------------------------
   chk_answer_one: assert property (cfg_wr |=> cfg_ack != cfg_reject)
      else $error("write not answered by exactly one of ack or reject");
   chk_answer_quiet: assert property (!cfg_wr |=> !cfg_ack && !cfg_reject)
      else $error("answer without a write");
   chk_hyst_limit: assert property (cfg_wr && cfg_sel != 2'h3 && cfg_item == 3'h2 && cfg_data > 16'h00C8
      |=> cfg_reject) else $error("hysteresis above limit accepted");
   chk_delay_limit: assert property (cfg_wr && cfg_sel != 2'h3 && cfg_item == 3'h3 && cfg_data > 16'h0E10
      |=> cfg_reject) else $error("ON delay above limit accepted");
   chk_tt_ready: assert property (cfg_wr && cfg_sel == 2'h3 && cfg_item == 3'h5 && !mode_ready
      |=> cfg_reject) else $error("time event type written outside ready");
   chk_tt_hold: assert property (!mode_ready |=> $stable(time_event_type))
      else $error("time event type changed outside ready");
   chk_timed_map: assert property (!$past(rst) |-> timed_output ==
      (($past(segment_no_bits) & seg_mask($past(time_event_type)))
      | ($past(time_event_bits) & ~seg_mask($past(time_event_type)))))
      else $error("timed output mapping wrong");
   chk_sb_ready: assert property (mode_ready |=> standby_active == 3'h7)
      else $error("standby not entered in ready");
   chk_sb_run: assert property (mode_ready ##1 (mode_run && !mode_ready) |=> standby_active == 3'h7)
      else $error("standby not held on ready to run");

   // Main scenarios reached
   cover property (cfg_wr ##1 cfg_reject);
   cover property ($rose(event_out[1]));
   cover property (mode_ready ##1 mode_run);
endmodule : evol_event_output_props

bind evol_event_output evol_event_output_props chk_u (.clk(clk), .rst(rst), .mode_ready(mode_ready),
   .mode_run(mode_run), .time_event_bits(time_event_bits), .segment_no_bits(segment_no_bits),
   .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_item(cfg_item), .cfg_data(cfg_data), .cfg_ack(cfg_ack),
   .cfg_reject(cfg_reject), .event_out(event_out), .standby_active(standby_active),
   .timed_output(timed_output), .time_event_type(time_event_type));

// File: evol_on_delay.sv
/*
 * ON delay timer for one event: counts whole seconds while the condition
 * holds and releases the output once more than the set delay has passed.
 * Assumes a one-cycle second tick from the same clock.
 */
`timescale 1ns/1ns
module evol_on_delay (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Timing
   input wire logic sec_tick,
   input wire logic [11:0] delay_s,
   // Condition and result
   input wire logic cond,
   output logic delayed_on
);

   logic [11:0] cnt_reg;
   logic [11:0] cnt_next;
   logic on_reg;
   logic on_next;

   // Seconds counter cleared whenever the condition drops
   always_comb begin
      cnt_next = cnt_reg;
      on_next = 1'b0;
      if (!cond) begin
         cnt_next = 12'h000;
      end else if (sec_tick && cnt_reg != 12'hFFF) begin
         cnt_next = cnt_reg + 12'h001;
      end
      // More than the delay: count must pass it, as a partial first second counts as a whole one
      on_next = cond && (delay_s == 12'h000 || cnt_reg > delay_s);
   end

   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 12'h000;
         on_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         on_reg <= on_next;
      end
   end

   assign delayed_on = on_reg;

endmodule : evol_on_delay

// File: evol_operator.sv
/*
 * Operator model: issues configuration writes one word at a time and
 * returns the block's answer.
 * Assumes the answer comes in the cycle after the taking edge.
 */
`timescale 1ns/1ns
module evol_operator (
   // Clock
   input wire logic clk,
   // Configuration port
   output logic cfg_wr,
   output logic [1:0] cfg_sel,
   output logic [2:0] cfg_item,
   output logic [15:0] cfg_data,
   input wire logic cfg_ack,
   input wire logic cfg_reject
);
   // Idle port
   initial begin
      cfg_wr = 1'b0;
      cfg_sel = 2'h0;
      cfg_item = 3'h0;
      cfg_data = 16'h0000;
   end

   // One write; ans is {ack, reject}
   task automatic put(input logic [1:0] s, input logic [2:0] i, input logic [15:0] d, output logic [1:0] ans);
      @(posedge clk);
      #1;
      cfg_wr = 1'b1;
      cfg_sel = s;
      cfg_item = i;
      cfg_data = d;
      @(posedge clk);
      #1;
      cfg_wr = 1'b0;
      cfg_data = ~d; // Released data shows no stale value
      ans = {cfg_ack, cfg_reject};
   endtask : put
endmodule : evol_operator

// File: evol_pkg.sv
/*
 * Constants shared by the event output logic: type codes, setting limits,
 * reset values of the operator settings and timing figures.
 * Assumes a single 10 MHz processing clock.
 */
package evol_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int EVOL_EVENTS = 3;
   localparam int EVOL_TIMED = 5;
   localparam int EVOL_STATUS_BITS = 17;

   // ------------------------------------------------------------
   // Event type codes
   // ------------------------------------------------------------
   localparam logic [7:0] EVOL_TYPE_MEAS_LAST = 8'h0B;
   localparam logic [7:0] EVOL_TYPE_TIME = 8'h32;
   localparam logic [7:0] EVOL_TYPE_UNAVAIL = 8'h32;
   localparam logic [7:0] EVOL_TYPE_STATUS_FIRST = 8'h64;
   localparam logic [7:0] EVOL_TYPE_STATUS_LAST = 8'h74;
   localparam logic [7:0] EVOL_TYPE_ADV = 8'h75;
   localparam logic [7:0] EVOL_TYPE_MAX = 8'hC7;

   // ------------------------------------------------------------
   // Setting limits
   // ------------------------------------------------------------
   localparam logic [15:0] EVOL_HYST_MAX = 16'h00C8;
   localparam logic [15:0] EVOL_DELAY_MAX = 16'h0E10;
   localparam logic [15:0] EVOL_STANDBY_MAX = 16'h0001;
   localparam logic [15:0] EVOL_TIME_TYPE_MAX = 16'h0005;

   // ------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] EVOL_TYPE_RST = 8'h00;
   localparam logic EVOL_STANDBY_ITEM_RST = 1'b0;
   localparam logic [7:0] EVOL_HYST_RST = 8'h05;
   localparam logic [11:0] EVOL_DELAY_RST = 12'h000;
   localparam logic [15:0] EVOL_POINT_RST = 16'h0000;
   localparam logic [2:0] EVOL_TIME_TYPE_RST = 3'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int EVOL_CLK_HZ = 10000000;
   localparam int EVOL_ADV_ON_MS = 1000;
   localparam int EVOL_SEC_CYCLES = EVOL_CLK_HZ / 1000 * EVOL_ADV_ON_MS;

   // ------------------------------------------------------------
   // Configuration items
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      EVOL_ITEM_TYPE = 3'h0,
      EVOL_ITEM_STANDBY = 3'h1,
      EVOL_ITEM_HYST = 3'h2,
      EVOL_ITEM_DELAY = 3'h3,
      EVOL_ITEM_POINT = 3'h4,
      EVOL_ITEM_TIME_TYPE = 3'h5
   } evol_item_t;

endpackage : evol_pkg

// File: testbench.sv
/*
 * Self-checking bench for the event output logic: comparisons, type codes,
 * standby, ON delay, advance pulse, timed outputs and refusals.
 * Assumes a 10 MHz clock and a second shortened to TPS cycles.
 */
`timescale 1ns/1ns
module testbench;
   localparam int TPS = 20;
   localparam logic [1:0] ACK = 2'b10;
   localparam logic [1:0] REJ = 2'b01;
   localparam logic [16:0] STAT_EXP = 17'h1FBC5;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] md = 5'h00;
   logic [9:0] st = 10'h000;
   logic advance_pulse = 1'b0;
   logic [15:0] pv = 16'h0000;
   logic [15:0] oq = 16'h0000;
   logic [2:0] evt_in = 3'h0;
   logic [4:0] tev = 5'h00;
   logic [4:0] seg = 5'h00;
   logic cfg_wr, cfg_ack, cfg_reject;
   logic [1:0] cfg_sel;
   logic [2:0] cfg_item, ev, sb, tet;
   logic [15:0] cfg_data;
   logic [4:0] tmo;
   int n_mismatch = 0;
   int cmp_count = 0;

   // 10 MHz clock
   always #50 clk = ~clk;

   evol_operator op_u (.clk(clk), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_item(cfg_item),
      .cfg_data(cfg_data), .cfg_ack(cfg_ack), .cfg_reject(cfg_reject));

   evol_event_output #(.TICKS_PER_SECOND(TPS)) dut_u (.clk(clk), .rst(rst), .mode_ready(md[0]),
      .mode_run(md[1]), .mode_hold(md[2]), .mode_fast(md[3]), .mode_end(md[4]), .gsoak_wait(st[0]),
      .manual_mode(st[1]), .autotune_busy(st[2]), .const_value_op(st[3]), .alarm_any(st[4]),
      .alarm_range(st[5]), .alarm_controller(st[6]), .battery_low(st[7]), .console_setup(st[8]),
      .loader_setup(st[9]), .advance_request(advance_pulse), .pv(pv), .deviation(oq), .setpoint(oq),
      .output_mv(oq), .motor_feedback(oq), .event_time_in(evt_in), .time_event_bits(tev),
      .segment_no_bits(seg), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_item(cfg_item),
      .cfg_data(cfg_data), .cfg_ack(cfg_ack), .cfg_reject(cfg_reject), .event_out(ev),
      .standby_active(sb), .timed_output(tmo), .time_event_type(tet));

   // --------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wr(input logic [1:0] s, input logic [2:0] i, input logic [15:0] d, input logic [1:0] e);
      logic [1:0] a;
      op_u.put(s, i, d, a);
      check(16'(a), 16'(e));
   endtask : wr

   task automatic step(input logic [15:0] v, input logic [1:0] e);
      pv = v;
      cyc(3);
      check(16'(ev[1:0]), 16'(e));
   endtask : step

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   // --------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------
   task automatic t_reset;
      @(posedge clk);
      #1;
      check(16'({sb, ev}), 16'h0038);
      cyc(2);
      rst = 1'b0;
   endtask : t_reset

   // Direct and reverse thresholds with hysteresis, exact latency
   task automatic t_compare;
      md = 5'h02;
      wr(2'h0, 3'h4, 16'h01F4, ACK);
      wr(2'h0, 3'h2, 16'h000A, ACK);
      wr(2'h1, 3'h0, 16'h0001, ACK);
      wr(2'h1, 3'h4, 16'h01F4, ACK);
      wr(2'h2, 3'h0, 16'h000C, ACK);
      cyc(4);
      pv = 16'h01F4;
      cyc(2);
      check(16'(ev), 16'h0002);
      cyc(1);
      check(16'(ev), 16'h0003);
      step(16'h01EF, 2'h3);
      step(16'h01E9, 2'h2);
      step(16'h01F9, 2'h3);
      step(16'h01FF, 2'h1);
   endtask : t_compare

   // Every measured code: even on, odd off above the point
   task automatic t_meas_codes;
      pv = 16'h0258;
      oq = 16'h0258;
      for (int t = 0; t < 12; t++) begin
         wr(2'h0, 3'h0, 16'(t), ACK);
         cyc(3);
         check(16'(ev[0]), 16'(t[0] == 1'b0));
      end
      // Negative deviation still trips the absolute type
      oq = 16'hFDA8;
      wr(2'h0, 3'h0, 16'h0004, ACK);
      cyc(3);
      check(16'(ev[0]), 16'h0001);
   endtask : t_meas_codes

   // Every status code with run mode and all status inputs set
   task automatic t_status;
      st = 10'h3FF;
      for (int t = 0; t < 17; t++) begin
         wr(2'h0, 3'h0, 16'(100 + t), ACK);
         cyc(3);
         check(16'(ev[0]), 16'(STAT_EXP[t]));
      end
      st = 10'h000;
      // Hold, fast and end each drive their own code
      for (int j = 0; j < 3; j++) begin
         md = 5'h04 << j;
         wr(2'h0, 3'h0, 16'(103 + j), ACK);
         cyc(3);
         check(16'(ev[0]), 16'h0001);
      end
      md = 5'h02;
   endtask : t_status

   task automatic t_standby;
      wr(2'h0, 3'h0, 16'h0000, ACK);
      wr(2'h0, 3'h1, 16'h0001, ACK);
      md = 5'h01;
      pv = 16'h0226;
      cyc(3);
      check(16'({sb[0], ev[0]}), 16'h0002);
      md = 5'h02;
      cyc(4);
      check(16'({sb[0], ev[0]}), 16'h0002);
      pv = 16'h01F3;
      cyc(3);
      check(16'(sb[0]), 16'h0000);
      step(16'h0226, 2'h1);
      wr(2'h0, 3'h0, 16'h0065, ACK);
      md = 5'h01;
      cyc(3);
      check(16'({sb[0], ev[0]}), 16'h0003);
      wr(2'h0, 3'h1, 16'h0000, REJ);
      wr(2'h0, 3'h2, 16'h000A, REJ);
      wr(2'h0, 3'h0, 16'h0032, ACK);
      evt_in = 3'h1;
      cyc(3);
      check(16'(ev[0]), 16'h0001);
   endtask : t_standby

   // Advance pulse lasts one second even with an ON delay set
   task automatic t_advance;
      int n;
      md = 5'h02;
      wr(2'h1, 3'h3, 16'h0002, ACK);
      wr(2'h1, 3'h0, 16'h0075, ACK);
      cyc(2);
      advance_pulse = 1'b1;
      cyc(1);
      advance_pulse = 1'b0;
      n = 0;
      repeat (3 * TPS) begin
         cyc(1);
         if (ev[1] === 1'b1) n++;
      end
      check(16'(n), 16'(TPS));
   endtask : t_advance

   task automatic t_refuse;
      wr(2'h2, 3'h2, 16'h00C9, REJ);
      wr(2'h2, 3'h2, 16'h00C8, ACK);
      wr(2'h2, 3'h3, 16'h0E11, REJ);
      wr(2'h2, 3'h3, 16'h0E10, ACK);
      wr(2'h2, 3'h0, 16'h00C8, REJ);
      wr(2'h2, 3'h1, 16'h0002, REJ);
      wr(2'h3, 3'h0, 16'h0000, REJ);
   endtask : t_refuse

   // Two second ON delay: output after more than two ticks
   task automatic t_delay;
      int n;
      wr(2'h2, 3'h0, 16'h0000, ACK);
      wr(2'h2, 3'h4, 16'h01F4, ACK);
      wr(2'h2, 3'h3, 16'h0002, ACK);
      pv = 16'h00C8;
      cyc(4);
      pv = 16'h0226;
      n = 0;
      while (ev[2] !== 1'b1 && n < 5 * TPS) begin
         cyc(1);
         n++;
      end
      check(16'(n > 2 * TPS && n <= 3 * TPS + 4), 16'h0001);
   endtask : t_delay

   task automatic t_timed;
      logic [4:0] m;
      md = 5'h01;
      tev = 5'h0A;
      seg = 5'h15;
      for (int k = 0; k < 6; k++) begin
         wr(2'h3, 3'h5, 16'(k), ACK);
         cyc(2);
         m = 5'((32'h1 << k) - 32'h1);
         check(16'(tmo), 16'((seg & m) | (tev & ~m)));
         check(16'(tet), 16'(k));
      end
      wr(2'h3, 3'h5, 16'h0006, REJ);
      md = 5'h02;
      wr(2'h3, 3'h5, 16'h0001, REJ);
      check(16'(tet), 16'h0005);
   endtask : t_timed

   // Main sequence
   initial begin
      t_reset;
      t_compare;
      t_meas_codes;
      t_status;
      t_standby;
      t_advance;
      t_refuse;
      t_delay;
      t_timed;
      tally_and_finish;
   end

   // Watchdog
   initial begin
      #(4000 * 100);
      n_mismatch++;
      tally_and_finish;
   end
endmodule : testbench
